// ### hw/egfs_sequencer.sv
// egress grant flywheel sequencer with axi4-lite control registers
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module egfs_sequencer #(
    parameter int MC_PERIOD = egfs_pkg::MC_PERIOD_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [egfs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [egfs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pkt_cycle,
    output logic oq_sel_half,
    output logic [1:0] oq_sel_prio,
    output logic [2:0] sp_sel_type,
    output logic [2:0] sp_sel_grp,
    input wire logic [15:0] oq_grant_word,
    input wire logic [15:0] sp_grant_word,
    input wire logic [7:0] mc_grant,
    input wire logic [3:0] scc_nibble,
    output logic hdr_valid,
    output logic [7:0] lo_qualifier_header_byte,
    output logic [7:0] lo_second_header_byte,
    output logic [7:0] lo_third_header_byte,
    output logic [7:0] hi_qualifier_header_byte,
    output logic [7:0] hi_second_header_byte,
    output logic [7:0] hi_third_header_byte,
    output logic [7:0] flow_control_byte,
    output logic [79:0] idle_lo_lane_unit,
    output logic [79:0] idle_hi_lane_unit
);
    localparam logic [egfs_pkg::MC_CNT_W-1:0] MC_LAST =
        egfs_pkg::MC_CNT_W'(MC_PERIOD - 1);

    if (MC_PERIOD < 2 || MC_PERIOD > (1 << egfs_pkg::MC_CNT_W))
    begin : g_bad_period
        $error("MC_PERIOD out of range");
    end

    // even parity over the header, parity bit itself taken as zero
    function automatic logic hdr_par(input logic [7:0] h0,
                                     input logic [7:0] h1,
                                     input logic [7:0] h2);
        hdr_par = ^{h0, h1, h2};
    endfunction

    function automatic logic [79:0] build_idle(input logic [7:0] h0,
                                               input logic [7:0] h1,
                                               input logic [7:0] h2,
                                               input logic [7:0] side_channel_byte,
                                               input logic [7:0] fc,
                                               input logic [7:0] comma);
        build_idle = {egfs_pkg::SYM_D21_5, egfs_pkg::SYM_D21_5, comma, fc,
                      side_channel_byte, egfs_pkg::SYM_D21_5, egfs_pkg::SYM_D21_5,
                      h2, h1, h0};
    endfunction

    // ---------------- register slave ----------------
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [egfs_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [7:0] wbyte_r, wbyte_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt, stat_word;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic cfg512;
    logic [1:0] nprio_m1, color;

    // flywheel state, declared here because status reads it
    logic half_r, half_nxt, pend_r, pend_nxt;
    logic [1:0] prio_r, prio_nxt;
    logic [2:0] spt_r, spt_nxt, grp_r, grp_nxt;
    logic [egfs_pkg::MC_CNT_W-1:0] mcc_r, mcc_nxt;
    logic [7:0] seen_r, seen_nxt;

    assign cfg512 = ctrl_r[egfs_pkg::CTRL_512_BIT];
    assign nprio_m1 = ctrl_r[egfs_pkg::CTRL_NPRIO_LSB +: 2];
    assign color = ctrl_r[egfs_pkg::CTRL_COLOR_LSB +: 2];
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[egfs_pkg::STAT_HALF_LSB] = half_r;
        stat_word[egfs_pkg::STAT_PRIO_LSB +: 2] = prio_r;
        stat_word[egfs_pkg::STAT_SPT_LSB +: 3] = spt_r;
        stat_word[egfs_pkg::STAT_GRP_LSB +: 3] = grp_r;
        stat_word[egfs_pkg::STAT_MCC_LSB +: egfs_pkg::MC_CNT_W] = mcc_r;
        stat_word[egfs_pkg::STAT_PEND_BIT] = pend_r;
    end

    always_comb
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wbyte_nxt = wbyte_r;
        wstrb0_nxt = wstrb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = {s_axi_awaddr[egfs_pkg::ADDR_W-1:2], 2'h0};
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_nxt = 1'b1;
            wbyte_nxt = s_axi_wdata[7:0];
            wstrb0_nxt = s_axi_wstrb[0];
        end
        // write commits one cycle after both halves are held
        if (aw_got_r && w_got_r)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = egfs_pkg::RESP_OKAY;
            if (awaddr_r == egfs_pkg::CTRL_OFS)
            begin
                if (wstrb0_r)
                    ctrl_nxt = wbyte_r;
            end
            else if (awaddr_r != egfs_pkg::STAT_OFS)
                bresp_nxt = egfs_pkg::RESP_DECERR;
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = egfs_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            unique case ({s_axi_araddr[egfs_pkg::ADDR_W-1:2], 2'h0})
                egfs_pkg::CTRL_OFS: rdata_nxt = {24'h00_0000, ctrl_r};
                egfs_pkg::STAT_OFS: rdata_nxt = stat_word;
                default: rresp_nxt = egfs_pkg::RESP_DECERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wbyte_r <= 8'h00;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= egfs_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= egfs_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= egfs_pkg::CTRL_RST;
        end
        else if (ce)
        begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wbyte_r <= wbyte_nxt;
            wstrb0_r <= wstrb0_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // ---------------- flywheels ----------------
    logic mc_changed, mc_sel;

    assign mc_changed = (mc_grant != seen_r);
    // a change seen in the send cycle itself is carried by that cycle
    assign mc_sel = (mcc_r == MC_LAST) || pend_r || mc_changed;
    assign oq_sel_half = half_r;
    assign oq_sel_prio = prio_r;
    assign sp_sel_type = spt_r;
    assign sp_sel_grp = grp_r;

    always_comb
    begin
        half_nxt = half_r;
        prio_nxt = prio_r;
        spt_nxt = spt_r;
        grp_nxt = grp_r;
        mcc_nxt = mcc_r;
        seen_nxt = mc_grant;
        pend_nxt = pend_r || mc_changed;
        if (pkt_cycle)
        begin
            half_nxt = !half_r;
            // priority on wrap; >= covers a count lowered at run time
            if (half_r)
                prio_nxt = (prio_r >= nprio_m1) ? 2'h0 : prio_r + 2'h1;
            // one cycle at multicast code, then full restart
            if (spt_r == egfs_pkg::SPT_MCAST)
            begin
                spt_nxt = 3'h0;
                grp_nxt = 3'h0;
            end
            else
            begin
                // group steps even while multicast is sent
                grp_nxt = grp_r + 3'h1;
                if (grp_r == egfs_pkg::GRP_LAST)
                    spt_nxt = (spt_r[1:0] >= nprio_m1) ?
                        egfs_pkg::SPT_MCAST : spt_r + 3'h1;
            end
            // periodic slot and pending change both consumed
            mcc_nxt = (mcc_r == MC_LAST) ? '0 : mcc_r + 1'b1;
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            half_r <= 1'b0;
            prio_r <= 2'h0;
            spt_r <= 3'h0;
            grp_r <= 3'h0;
            mcc_r <= '0;
            pend_r <= 1'b0;
            seen_r <= 8'h00;
        end
        else if (ce)
        begin
            half_r <= half_nxt;
            prio_r <= prio_nxt;
            spt_r <= spt_nxt;
            grp_r <= grp_nxt;
            mcc_r <= mcc_nxt;
            pend_r <= pend_nxt;
            seen_r <= seen_nxt;
        end
    end

    // ---------------- header assembly ----------------
    logic [7:0] lo_h0, lo_h1, lo_h2, hi_h0, hi_h1, hi_h2, fc, side_channel_byte;
    logic [7:0] lo_h0_r, lo_h1_r, lo_h2_r, hi_h0_r, hi_h1_r, hi_h2_r, fc_r;
    logic [79:0] idle_lo_r, idle_hi_r, idle_lo_nxt, idle_hi_nxt;
    logic hdr_valid_r;

    always_comb
    begin
        side_channel_byte = {scc_nibble, scc_nibble};
        // flow-control byte holds type and group
        fc = {2'h0, spt_r, grp_r};
        // queue grants of the selected half and priority
        lo_h1 = oq_grant_word[7:0];
        lo_h2 = cfg512 ? oq_grant_word[15:8] : egfs_pkg::SYM_D21_5;
        // subport grants, replaced by multicast on
        hi_h1 = mc_sel ? mc_grant : sp_grant_word[7:0];
        hi_h2 = egfs_pkg::SYM_D21_5;
        if (cfg512)
            hi_h2 = (mc_sel || spt_r == egfs_pkg::SPT_MCAST) ?
                8'h00 : sp_grant_word[15:8];
        // low qualifier carries half and priority status
        lo_h0 = 8'h00;
        lo_h0[0] = half_r;
        lo_h0[egfs_pkg::H0_COLOR_LSB +: 2] = color;
        lo_h0[egfs_pkg::H0_PRIO_LSB +: 2] = prio_r;
        lo_h0[egfs_pkg::H0_PAR_BIT] =
            hdr_par(lo_h0, lo_h1, cfg512 ? lo_h2 : 8'h00);
        hi_h0 = 8'h00;
        hi_h0[0] = mc_sel;
        hi_h0[egfs_pkg::H0_COLOR_LSB +: 2] = color;
        hi_h0[egfs_pkg::H0_PAR_BIT] =
            hdr_par(hi_h0, hi_h1, cfg512 ? hi_h2 : 8'h00);
        idle_lo_nxt = build_idle(lo_h0, lo_h1, lo_h2, side_channel_byte, fc,
                                 egfs_pkg::SYM_K28_5);
        idle_hi_nxt = build_idle(hi_h0, hi_h1, hi_h2, side_channel_byte, fc,
                                 egfs_pkg::SYM_K28_1);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hdr_valid_r <= 1'b0;
            lo_h0_r <= 8'h00;
            lo_h1_r <= 8'h00;
            lo_h2_r <= 8'h00;
            hi_h0_r <= 8'h00;
            hi_h1_r <= 8'h00;
            hi_h2_r <= 8'h00;
            fc_r <= 8'h00;
            idle_lo_r <= '0;
            idle_hi_r <= '0;
        end
        else if (ce)
        begin
            hdr_valid_r <= pkt_cycle;
            if (pkt_cycle)
            begin
                lo_h0_r <= lo_h0;
                lo_h1_r <= lo_h1;
                lo_h2_r <= lo_h2;
                hi_h0_r <= hi_h0;
                hi_h1_r <= hi_h1;
                hi_h2_r <= hi_h2;
                fc_r <= fc;
                idle_lo_r <= idle_lo_nxt;
                idle_hi_r <= idle_hi_nxt;
            end
        end
    end

    assign hdr_valid = hdr_valid_r;
    assign lo_qualifier_header_byte = lo_h0_r;
    assign lo_second_header_byte = lo_h1_r;
    assign lo_third_header_byte = lo_h2_r;
    assign hi_qualifier_header_byte = hi_h0_r;
    assign hi_second_header_byte = hi_h1_r;
    assign hi_third_header_byte = hi_h2_r;
    assign flow_control_byte = fc_r;
    assign idle_lo_lane_unit = idle_lo_r;
    assign idle_hi_lane_unit = idle_hi_r;

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic adv;
    assign adv = ce && pkt_cycle;

    sequence s_mc_slot;
        adv && spt_r == egfs_pkg::SPT_MCAST;
    endsequence
    sequence s_restart;
        spt_r == 3'h0 && grp_r == 3'h0;
    endsequence

    chk_half_toggle: assert property (adv |=> half_r != $past(half_r))
        else $error("port-half counter did not toggle");
    chk_prio_hold: assert property (adv && !half_r |=> $stable(prio_r))
        else $error("priority moved without half wrap");
    chk_prio_wrap: assert property (adv && half_r && prio_r == nprio_m1
        |=> prio_r == 2'h0)
        else $error("priority did not return to zero");
    chk_type_range: assert property (spt_r <= egfs_pkg::SPT_MCAST)
        else $error("subport type counter out of range");
    chk_mc_restart: assert property (s_mc_slot |=> s_restart)
        else $error("counter did not restart after multicast slot");
    chk_group_step: assert property (adv && spt_r != egfs_pkg::SPT_MCAST
        |=> grp_r == $past(grp_r) + 3'h1)
        else $error("port-group counter did not advance");
    chk_period_sub: assert property (adv && mcc_r == MC_LAST
        |=> hi_h0_r[0] && hi_h1_r == $past(mc_grant))
        else $error("periodic multicast substitution missing");
    chk_change_sub: assert property (adv && pend_r |=> hi_h0_r[0])
        else $error("multicast change not sent next cycle");
    chk_lo_status: assert property (adv |=> lo_h0_r[0] == $past(half_r)
        && lo_h0_r[egfs_pkg::H0_PRIO_LSB +: 2] == $past(prio_r))
        else $error("low qualifier status wrong");
    chk_fc_status: assert property (adv
        |=> fc_r == {2'h0, $past(spt_r), $past(grp_r)})
        else $error("flow-control byte status wrong");
    chk_reset_zero: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> !half_r && prio_r == 2'h0 && spt_r == 3'h0
        && grp_r == 3'h0)
        else $error("counters not zero after reset");
endmodule
`default_nettype wire

// ### pkg/egfs_pkg.sv
// constants shared by the egress grant flywheel sequencer
package egfs_pkg;
    // register map (byte addresses on the axi4-lite slave)
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;

    // control register layout
    localparam int CTRL_512_BIT = 0;
    localparam int CTRL_NPRIO_LSB = 1;
    localparam int CTRL_COLOR_LSB = 3;
    localparam logic [7:0] CTRL_RST = 8'h06;

    // status register layout
    localparam int STAT_HALF_LSB = 0;
    localparam int STAT_PRIO_LSB = 1;
    localparam int STAT_SPT_LSB = 3;
    localparam int STAT_GRP_LSB = 6;
    localparam int STAT_MCC_LSB = 9;
    localparam int STAT_PEND_BIT = 15;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // 8b/10b symbol values handed to the encoder (k flag kept outside)
    localparam logic [7:0] SYM_K28_1 = 8'h3c;
    localparam logic [7:0] SYM_K28_5 = 8'hbc;
    localparam logic [7:0] SYM_D21_5 = 8'hb5;

    // flywheel codes
    localparam logic [2:0] SPT_MCAST = 3'h4;
    localparam logic [2:0] GRP_LAST = 3'h7;
    localparam int MC_PERIOD_DEF = 61;
    localparam int MC_CNT_W = 6;

    // qualifier byte fields
    localparam int H0_PAR_BIT = 1;
    localparam int H0_COLOR_LSB = 4;
    localparam int H0_PRIO_LSB = 6;
endpackage

// ### testbench/egfs_adapter_model.sv
// adapter-side model that follows the grant flywheels from idle status
`timescale 1ns/1ps
`default_nettype none
module egfs_adapter_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hdr_valid,
    input wire logic [1:0] nprio_m1,
    input wire logic [7:0] lo_qualifier_header_byte,
    input wire logic [7:0] flow_control_byte,
    output logic [7:0] sync_err
);
    logic aligned_r;
    logic [8:0] trk_r;
    logic [8:0] seen;
    logic [8:0] step;
    logic [1:0] prio;
    logic [2:0] spt;
    logic [2:0] grp;
    // predict the status that the next packet must report
    always_comb
    begin
        seen = {lo_qualifier_header_byte[7:6], lo_qualifier_header_byte[0],
                flow_control_byte[5:0]};
        prio = seen[8:7];
        if (seen[6])
            prio = (prio >= nprio_m1) ? 2'h0 : prio + 2'h1;
        spt = seen[5:3];
        grp = seen[2:0] + 3'h1;
        if (seen[5:3] == 3'h4)
            {spt, grp} = 6'h00;
        else if (grp == 3'h0)
            spt = (spt >= {1'b0, nprio_m1}) ? 3'h4 : spt + 3'h1;
        step = {prio, ~seen[6], spt, grp};
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aligned_r <= 1'b0;
            trk_r <= 9'h000;
            sync_err <= 8'h00;
        end
        else if (hdr_valid)
        begin
            if (aligned_r && seen != trk_r)
                sync_err <= sync_err + 8'h01;
            aligned_r <= 1'b1;
            trk_r <= step;
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the egress grant flywheel sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int MCP = 7;
    logic aclk, aresetn, ce, pkt_cycle, hdr_valid, oq_sel_half;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, scc_nibble;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, pend, m512, mcs, chg, e_hv, prev_pkt;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, oq_sel_prio, color, resp;
    logic [2:0] sp_sel_type, sp_sel_grp;
    logic [15:0] oq_grant_word, sp_grant_word;
    logic [7:0] mc_grant, lo_qualifier_header_byte, lo_second_header_byte;
    logic [7:0] lo_third_header_byte, hi_qualifier_header_byte;
    logic [7:0] hi_second_header_byte, hi_third_header_byte;
    logic [7:0] flow_control_byte, sync_err, last;
    logic [7:0] lo0, lo1, lo2, hi0, hi1, hi2, fc;
    logic [79:0] idle_lo_lane_unit, idle_hi_lane_unit, e_il, e_ih;
    logic [31:0] cfg [4] = '{32'h1f, 32'h08, 32'h13, 32'h04};
    int error_cnt, comparisons, half, prio, spt, grp, mcc, np;

    egfs_sequencer #(.MC_PERIOD(MCP)) DUT (.aclk, .aresetn, .ce,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pkt_cycle, .oq_sel_half, .oq_sel_prio, .sp_sel_type,
        .sp_sel_grp, .oq_grant_word, .sp_grant_word, .mc_grant, .scc_nibble,
        .hdr_valid, .lo_qualifier_header_byte, .lo_second_header_byte,
        .lo_third_header_byte, .hi_qualifier_header_byte,
        .hi_second_header_byte, .hi_third_header_byte, .flow_control_byte,
        .idle_lo_lane_unit, .idle_hi_lane_unit);
    egfs_adapter_model PEER (.aclk, .aresetn, .hdr_valid,
        .nprio_m1(2'(np)), .lo_qualifier_header_byte, .flow_control_byte,
        .sync_err);

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            return x ^ (x << 5);
        end
    endfunction

    function automatic logic [31:0] stat_exp();
        return {16'h0, pend, 6'(mcc), 3'(grp), 3'(spt), 2'(prio), 1'(half)};
    endfunction

    task automatic chk(input string nm, input logic [79:0] seen,
                       input logic [79:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                error_cnt++;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task automatic tally_and_finish();
        begin
            if (error_cnt == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, da, dw;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            {da, dw, n} = '0;
            while (!(da && dw) && n < 50)
            begin
                @(negedge aclk);
                ta = s_axi_awvalid && s_axi_awready;
                tw = s_axi_wvalid && s_axi_wready;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                da = da | ta;
                dw = dw | tw;
                n++;
            end
            do @(negedge aclk); while (!s_axi_bvalid && ++n < 100);
            chk("bvalid", s_axi_bvalid, 1'b1);
            resp = s_axi_bresp;
            @(posedge aclk);
            s_axi_bready <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [3:0] a);
        int n;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            n = 0;
            do @(negedge aclk); while (!s_axi_arready && ++n < 50);
            @(posedge aclk);
            s_axi_arvalid <= 1'b0;
            do @(negedge aclk); while (!s_axi_rvalid && ++n < 100);
            chk("rvalid", s_axi_rvalid, 1'b1);
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            s_axi_rready <= 1'b0;
        end
    endtask

    // ce drops only after an idle cycle so hdr_valid is never frozen high
    task automatic run(input int n);
        logic [31:0] r;
        begin
            repeat (n)
            begin
                @(posedge aclk);
                seed = xs(seed);
                r = seed;
                prev_pkt = (r[10:8] == 3'h0 && !prev_pkt) ? 1'b0 : r[0] | r[1];
                ce <= !(r[10:8] == 3'h0 && !pkt_cycle);
                pkt_cycle <= prev_pkt;
                oq_grant_word <= r[31:16];
                sp_grant_word <= r[15:0] ^ r[31:16];
                scc_nibble <= r[15:12];
                if (r[7:4] == 4'h0) mc_grant <= r[27:20];
            end
            @(posedge aclk);
            pkt_cycle <= 1'b0;
            ce <= 1'b1;
            prev_pkt = 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask

    // reference model of the flywheels and header bytes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {half, prio, spt, grp, mcc, np} = {32'h0, 32'h0, 32'h0, 32'h0,
                                               32'h0, 32'h3};
            {pend, last, e_hv, m512, color} = '0;
            {lo0, lo1, lo2, hi0, hi1, hi2, fc, e_il, e_ih} = '0;
        end
        else if (ce)
        begin
            chg = mc_grant !== last;
            e_hv = pkt_cycle;
            if (pkt_cycle)
            begin
                mcs = (mcc == MCP - 1) || pend || chg;
                lo0 = {2'(prio), color, 3'h0, 1'(half)};
                lo1 = oq_grant_word[7:0];
                lo2 = m512 ? oq_grant_word[15:8] : egfs_pkg::SYM_D21_5;
                lo0[1] = ^{lo0, lo1, m512 ? lo2 : 8'h00};
                hi0 = {2'h0, color, 3'h0, mcs};
                hi1 = mcs ? mc_grant : sp_grant_word[7:0];
                hi2 = !m512 ? egfs_pkg::SYM_D21_5 :
                      (mcs || spt == 4) ? 8'h00 : sp_grant_word[15:8];
                hi0[1] = ^{hi0, hi1, m512 ? hi2 : 8'h00};
                fc = {2'h0, 3'(spt), 3'(grp)};
                e_il = {{2{egfs_pkg::SYM_D21_5}}, egfs_pkg::SYM_K28_5, fc,
                        {2{scc_nibble}}, {2{egfs_pkg::SYM_D21_5}}, lo2, lo1, lo0};
                e_ih = {{2{egfs_pkg::SYM_D21_5}}, egfs_pkg::SYM_K28_1, fc,
                        {2{scc_nibble}}, {2{egfs_pkg::SYM_D21_5}}, hi2, hi1, hi0};
                half = 1 - half;
                if (half == 0) prio = (prio >= np) ? 0 : prio + 1;
                if (spt == 4) {spt, grp} = '0;
                else
                begin
                    grp = (grp + 1) % 8;
                    if (grp == 0) spt = (spt >= np) ? 4 : spt + 1;
                end
                mcc = (mcc == MCP - 1) ? 0 : mcc + 1;
            end
            pend = !pkt_cycle && (pend || chg);
            last = mc_grant;
        end
    end

    always @(negedge aclk)
    begin
        if (aresetn)
        begin
            chk("sel", {oq_sel_half, oq_sel_prio, sp_sel_type, sp_sel_grp},
                {1'(half), 2'(prio), 3'(spt), 3'(grp)});
            chk("hdr_valid", hdr_valid, e_hv);
            chk("lo_hdr", {lo_qualifier_header_byte, lo_second_header_byte,
                lo_third_header_byte}, {lo0, lo1, lo2});
            chk("hi_hdr", {hi_qualifier_header_byte, hi_second_header_byte,
                hi_third_header_byte}, {hi0, hi1, hi2});
            chk("fc", flow_control_byte, fc);
            chk("idle_lo", idle_lo_lane_unit, e_il);
            chk("idle_hi", idle_hi_lane_unit, e_ih);
        end
    end

    initial
    begin
        {aresetn, pkt_cycle, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, oq_grant_word, sp_grant_word, mc_grant} = '0;
        {scc_nibble, prev_pkt, error_cnt, comparisons} = '0;
        {ce, s_axi_wstrb, seed} = {1'b1, 4'hf, 32'h3b27};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(egfs_pkg::CTRL_OFS);
        chk("ctrl", {rd, resp}, {32'(egfs_pkg::CTRL_RST), egfs_pkg::RESP_OKAY});
        axi_rd(4'h8);
        chk("rd_unmapped", {rd, resp}, {32'h0, egfs_pkg::RESP_DECERR});
        axi_wr(4'hc, 32'h0);
        chk("wr_unmapped", resp, egfs_pkg::RESP_DECERR);
        axi_wr(egfs_pkg::STAT_OFS, 32'hffff);
        axi_rd(egfs_pkg::STAT_OFS);
        chk("stat", {rd, resp}, {stat_exp(), egfs_pkg::RESP_OKAY});
        for (int c = 0; c < 5; c++)
        begin
            if (c == 4)
            begin
                aresetn <= 1'b0;
                repeat (2) @(posedge aclk);
                aresetn <= 1'b1;
            end
            else
            begin
                axi_wr(egfs_pkg::CTRL_OFS, cfg[c]);
                chk("ctrl_wr", resp, egfs_pkg::RESP_OKAY);
                {color, np, m512} = {cfg[c][4:3], 30'h0, cfg[c][2:1], cfg[c][0]};
                axi_rd(egfs_pkg::CTRL_OFS);
                chk("ctrl_rd", rd, cfg[c]);
            end
            run(160);
            axi_rd(egfs_pkg::STAT_OFS);
            chk("stat", {rd, resp}, {stat_exp(), egfs_pkg::RESP_OKAY});
        end
        chk("peer_sync", sync_err, 8'h00);
        tally_and_finish();
    end

    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
